// ### logic/eeprom_pkg.sv
`default_nettype none
package eeprom_pkg;

    // array geometry
    localparam int AW          = 11;               // word address bits, 2K bytes
    localparam int PAGE_BITS   = 6;                // 64-byte page
    localparam int PAGE_BYTES  = 1 << PAGE_BITS;
    localparam int BYTE_BITS   = 8;

    // slave address byte layout: type[7:4], zero[3], select[2:1], rw[0]
    localparam logic [3:0] DEV_TYPE    = 4'ha;
    localparam int         TYPE_LSB    = 4;
    localparam int         ZERO_BIT    = 3;
    localparam int         SEL_LSB     = 1;
    localparam int         RW_BIT      = 0;
    localparam logic [3:0] BIT_ACK_POS = 4'h8;     // bit count at which a byte is complete

    // timing
    localparam int CLK_PERIOD_NS  = 50;            // 20 MHz system clock
    localparam int LINK_PERIOD_NS = 125;           // device-side link clock
    localparam int SCL_PERIOD_NS  = 2500;          // 400 kHz serial clock, least period
    localparam int T_WR_NS        = 5000000;       // nonvolatile write cycle, typical
    localparam int QTR_CYC = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CYCLES      = T_WR_NS / LINK_PERIOD_NS;

    // master command codes
    typedef enum logic [1:0] {
        OP_START,
        OP_STOP,
        OP_WRITE,
        OP_READ
    } op_t;

    // master step counts
    localparam logic [5:0] STEP_COND_LAST = 6'h03; // start/stop: four quarters
    localparam logic [5:0] STEP_BYTE_LAST = 6'h23; // byte: nine bits of four quarters

endpackage : eeprom_pkg
`default_nettype wire

// ### logic/two_wire_if.sv
`timescale 1ns/100ps
`default_nettype none
interface two_wire_if;
    logic m_scl_o;     // master clock drive value
    logic m_scl_oe;    // master drives clock
    logic m_sda_o;     // master data drive value
    logic m_sda_oe;    // master drives data
    logic s_sda_o;     // device data drive value
    logic s_sda_oe;    // device drives data
    logic scl;         // resolved clock wire
    logic sda;         // resolved data wire

    // open-drain wires with pull-ups
    assign scl = m_scl_oe ? m_scl_o : 1'b1;
    assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

    modport mst (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
                 input scl, input sda);
    modport dev (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface : two_wire_if
`default_nettype wire

// ### logic/eeprom_link_dev.sv
`timescale 1ns/100ps
`default_nettype none
module eeprom_link_dev
    import eeprom_pkg::*;
#(
    parameter int WR_CYC = WR_CYCLES                 // write cycle length in link clocks
)(
    input  wire logic          link_clk,             // link clock
    input  wire logic          sys_rst,              // async reset, active high
    two_wire_if.dev            bus,                  // serial pins
    input  wire logic [1:0]    dev_sel,              // strapped select bits
    input  wire logic          rst_out_active,       // supervisor reset output asserted
    input  wire logic          wp_hit,               // word_addr lies in a protected block
    input  wire logic [7:0]    rd_data,              // array byte at word_addr
    output logic [AW-1:0]      word_addr,            // address counter
    output logic               nv_we,                // array write strobe
    output logic [AW-1:0]      nv_addr,              // array write address
    output logic [7:0]         nv_data,              // array write data
    output logic               nv_busy               // nonvolatile cycle in progress
);

    typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK, ST_COMMIT, ST_BUSY} st_t;
    typedef enum {K_SLAVE, K_AHI, K_ALO, K_DATA} kind_t;

    // slave address compare
    function automatic logic slave_match(input logic [7:0] b, input logic [1:0] sel);
        slave_match = (b[TYPE_LSB +: 4] == DEV_TYPE) && !b[ZERO_BIT]
                      && (b[SEL_LSB +: 2] == sel);
    endfunction : slave_match

    // next write address, wrapping inside the page
    function automatic logic [AW-1:0] page_inc(input logic [AW-1:0] a);
        page_inc = {a[AW-1:PAGE_BITS], a[PAGE_BITS-1:0] + 1'b1};
    endfunction : page_inc

    logic                  scl_m_r, scl_s_r, scl_p_r;
    logic                  sda_m_r, sda_s_r, sda_p_r;
    logic                  rst_m_r, rst_s_r;
    st_t                   st_r;
    kind_t                 kind_r;
    logic [3:0]            bit_cnt_r;
    logic [7:0]            sh_r;
    logic [7:0]            ahi_r;
    logic                  ack_r;
    logic                  rd_mode_r;
    logic                  mack_r;
    logic                  ndata_r;
    logic [AW-1:0]         cnt_r;
    logic [PAGE_BITS:0]    idx_r;
    logic [31:0]           tmr_r;
    logic                  sda_oe_r;
    logic                  sda_o_r;
    logic [7:0]            buf_mem [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] buf_vld_r;

    logic scl_rise, scl_fall, start_c, stop_c, byte_done, load_byte, busy, commit_end;

    // pins and the reset output cross into the link domain through two flops each
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_p_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_p_r <= 1'b1;
            rst_m_r <= 1'b0;
            rst_s_r <= 1'b0;
        end else begin
            scl_m_r <= bus.scl;
            scl_s_r <= scl_m_r;
            scl_p_r <= scl_s_r;
            sda_m_r <= bus.sda;
            sda_s_r <= sda_m_r;
            sda_p_r <= sda_s_r;
            rst_m_r <= rst_out_active;
            rst_s_r <= rst_m_r;
        end
    end

    // bus events; a data edge while clock stays high is a condition, not data
    assign scl_rise   = scl_s_r & ~scl_p_r;
    assign scl_fall   = ~scl_s_r & scl_p_r;
    assign start_c    = scl_s_r & scl_p_r & sda_p_r & ~sda_s_r;
    assign stop_c     = scl_s_r & scl_p_r & ~sda_p_r & sda_s_r;
    assign busy       = (st_r == ST_COMMIT) || (st_r == ST_BUSY);
    assign byte_done  = (st_r == ST_RX) && scl_fall && (bit_cnt_r == BIT_ACK_POS);
    assign load_byte  = byte_done && (kind_r == K_DATA) && !wp_hit && !rst_s_r;
    assign commit_end = (st_r == ST_COMMIT) && (idx_r == PAGE_BYTES[PAGE_BITS:0] - 1'b1);

    // protocol engine; outputs to the pin change only after a clock fall, except the release on the reset output
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r      <= ST_IDLE;
            kind_r    <= K_SLAVE;
            bit_cnt_r <= 4'h0;
            sh_r      <= 8'h00;
            ahi_r     <= 8'h00;
            ack_r     <= 1'b0;
            rd_mode_r <= 1'b0;
            mack_r    <= 1'b0;
            ndata_r   <= 1'b0;
            cnt_r     <= '0;
            idx_r     <= '0;
            tmr_r     <= 32'h0000_0000;
            sda_oe_r  <= 1'b0;
        end else if (rst_s_r && !busy) begin
            st_r     <= ST_IDLE;
            sda_oe_r <= 1'b0;
        end else if (st_r == ST_COMMIT) begin
            sda_oe_r <= 1'b0;
            idx_r    <= idx_r + 1'b1;
            if (commit_end) begin
                st_r  <= ST_BUSY;
                tmr_r <= 32'h0000_0000;
            end
        end else if (st_r == ST_BUSY) begin
            // inputs ignored, so polling addresses go unanswered
            sda_oe_r <= 1'b0;
            tmr_r    <= tmr_r + 32'h0000_0001;
            if (tmr_r >= 32'(WR_CYC - 1)) begin
                st_r <= ST_IDLE;
            end
        end else if (start_c) begin
            st_r      <= ST_RX;
            kind_r    <= K_SLAVE;
            bit_cnt_r <= 4'h0;
            ndata_r   <= 1'b0;
            sda_oe_r  <= 1'b0;
        end else if (stop_c) begin
            sda_oe_r <= 1'b0;
            // write only after whole data byte plus its ack, never mid-byte;
            // the stop's own clock rise has already counted one bit here
            if (kind_r == K_DATA && st_r == ST_RX && bit_cnt_r == 4'h1 && ndata_r) begin
                st_r  <= ST_COMMIT;
                idx_r <= '0;
            end else begin
                st_r <= ST_IDLE;
            end
        end else begin
            case (st_r)
                ST_RX: begin
                    if (scl_rise) begin
                        sh_r      <= {sh_r[6:0], sda_s_r};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (byte_done) begin
                        st_r <= ST_ACK;
                        case (kind_r)
                            K_SLAVE: begin
                                ack_r     <= slave_match(sh_r, dev_sel);
                                sda_oe_r  <= slave_match(sh_r, dev_sel);
                                rd_mode_r <= sh_r[RW_BIT];
                                kind_r    <= K_AHI;
                            end
                            K_AHI: begin
                                ahi_r    <= sh_r;
                                ack_r    <= 1'b1;
                                sda_oe_r <= 1'b1;
                                kind_r   <= K_ALO;
                            end
                            K_ALO: begin
                                cnt_r    <= AW'({ahi_r, sh_r});
                                ack_r    <= 1'b1;
                                sda_oe_r <= 1'b1;
                                kind_r   <= K_DATA;
                            end
                            default: begin
                                ack_r    <= !wp_hit;
                                sda_oe_r <= !wp_hit;
                                if (!wp_hit) begin
                                    cnt_r   <= page_inc(cnt_r);
                                    ndata_r <= 1'b1;
                                end
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        if (!ack_r) begin
                            st_r     <= ST_IDLE;
                            sda_oe_r <= 1'b0;
                        end else if (rd_mode_r && kind_r == K_AHI) begin
                            // current or random read starts at the counter
                            st_r     <= ST_TX;
                            sh_r     <= rd_data;
                            cnt_r    <= cnt_r + 1'b1;
                            sda_oe_r <= ~rd_data[7];
                        end else begin
                            st_r     <= ST_RX;
                            sda_oe_r <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_r == BIT_ACK_POS) begin
                            st_r     <= ST_RACK;
                            sda_oe_r <= 1'b0;
                        end else begin
                            sh_r     <= {sh_r[6:0], 1'b0};
                            sda_oe_r <= ~sh_r[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        mack_r <= ~sda_s_r;
                    end else if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        if (mack_r) begin
                            st_r     <= ST_TX;
                            sh_r     <= rd_data;
                            cnt_r    <= cnt_r + 1'b1;
                            sda_oe_r <= ~rd_data[7];
                        end else begin
                            st_r <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // page buffer holds loaded bytes; a later byte to a slot replaces it
    always_ff @(posedge link_clk) begin
        if (load_byte) begin
            buf_mem[cnt_r[PAGE_BITS-1:0]] <= sh_r;
        end
    end

    // slot valid flags, cleared on each new transfer and after commit
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            buf_vld_r <= '0;
        end else if (commit_end || (start_c && !busy)) begin
            buf_vld_r <= '0;
        end else if (load_byte) begin
            buf_vld_r[cnt_r[PAGE_BITS-1:0]] <= 1'b1;
        end
    end

    // commit walks the page, one slot per link clock
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nv_we   <= 1'b0;
            nv_addr <= '0;
            nv_data <= 8'h00;
            nv_busy <= 1'b0;
        end else begin
            nv_we   <= (st_r == ST_COMMIT) && buf_vld_r[idx_r[PAGE_BITS-1:0]];
            nv_addr <= {cnt_r[AW-1:PAGE_BITS], idx_r[PAGE_BITS-1:0]};
            nv_data <= buf_mem[idx_r[PAGE_BITS-1:0]];
            nv_busy <= busy;
        end
    end

    // open-drain drive: only ever pulls low
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sda_o_r <= 1'b0;
        end else begin
            sda_o_r <= 1'b0;
        end
    end

    assign bus.s_sda_oe = sda_oe_r;
    assign bus.s_sda_o  = sda_o_r;
    assign word_addr    = cnt_r;

endmodule : eeprom_link_dev
`default_nettype wire

// ### logic/two_wire_master.sv
`timescale 1ns/100ps
`default_nettype none
module two_wire_master
    import eeprom_pkg::*;
#(
    parameter int QTR = QTR_CYC                      // system clocks per quarter bit
)(
    input  wire logic       clock,                   // system clock
    input  wire logic       sys_rst,                 // async reset, active high
    two_wire_if.mst         bus,                     // serial pins
    input  wire logic       cmd_valid,               // command request
    input  wire op_t        cmd_op,                  // start, stop, write byte, read byte
    input  wire logic [7:0] cmd_data,                // byte to write
    input  wire logic       cmd_mack,                // acknowledge a read byte
    output logic            cmd_ready,               // idle, command accepted
    output logic            rsp_valid,               // command finished, one cycle
    output logic [7:0]      rsp_data,                // byte read
    output logic            rsp_ack                  // device acknowledged written byte
);

    logic       sda_m_r, sda_s_r;
    logic       run_r;
    op_t        op_r;
    logic [5:0] step_r;
    logic [7:0] sh_r;
    logic       mack_r;
    logic [15:0] div_r;
    logic       scl_oe_r, sda_oe_r, zero_r;
    logic       tick, last;
    logic [1:0] q;
    logic [3:0] bitn;

    assign tick = run_r && (div_r == 16'(QTR - 1));
    assign q    = step_r[1:0];
    assign bitn = step_r[5:2];
    assign last = (op_r == OP_START || op_r == OP_STOP) ? (step_r == STEP_COND_LAST)
                                                        : (step_r == STEP_BYTE_LAST);

    // data pin returns through two flops
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
        end else begin
            sda_m_r <= bus.sda;
            sda_s_r <= sda_m_r;
        end
    end

    // quarter-bit divider makes the serial clock
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            div_r <= 16'h0000;
        end else if (!run_r || tick) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end

    // command sequencer; byte data moves only in quarter 0, clock low; start and stop also move it in quarter 2, clock high
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            run_r     <= 1'b0;
            op_r      <= OP_START;
            step_r    <= 6'h00;
            sh_r      <= 8'h00;
            mack_r    <= 1'b0;
            scl_oe_r  <= 1'b0;
            sda_oe_r  <= 1'b0;
            zero_r    <= 1'b0;
            cmd_ready <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_data  <= 8'h00;
            rsp_ack   <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            zero_r    <= 1'b0;
            if (!run_r) begin
                if (cmd_valid) begin
                    run_r     <= 1'b1;
                    cmd_ready <= 1'b0;
                    op_r      <= cmd_op;
                    sh_r      <= cmd_data;
                    mack_r    <= cmd_mack;
                    step_r    <= 6'h00;
                end
            end else if (tick) begin
                step_r <= step_r + 6'h01;
                case (op_r)
                    OP_START: begin
                        case (q)
                            2'h0:    sda_oe_r <= 1'b0;
                            2'h1:    scl_oe_r <= 1'b0;
                            2'h2:    sda_oe_r <= 1'b1;
                            default: scl_oe_r <= 1'b1;
                        endcase
                    end
                    OP_STOP: begin
                        case (q)
                            2'h0:    sda_oe_r <= 1'b1;
                            2'h1:    scl_oe_r <= 1'b0;
                            2'h2:    sda_oe_r <= 1'b0;
                            default: sda_oe_r <= 1'b0;
                        endcase
                    end
                    default: begin
                        case (q)
                            2'h0: begin
                                if (op_r == OP_WRITE) begin
                                    sda_oe_r <= (bitn < 4'h8) ? ~sh_r[7] : 1'b0;
                                end else begin
                                    sda_oe_r <= (bitn < 4'h8) ? 1'b0 : mack_r;
                                end
                            end
                            2'h1: scl_oe_r <= 1'b0;
                            2'h2: begin
                                if (bitn == 4'h8) begin
                                    rsp_ack <= ~sda_s_r;
                                end else if (op_r == OP_READ) begin
                                    sh_r <= {sh_r[6:0], sda_s_r};
                                end
                            end
                            default: begin
                                scl_oe_r <= 1'b1;
                                if (op_r == OP_WRITE) begin
                                    sh_r <= {sh_r[6:0], 1'b0};
                                end
                            end
                        endcase
                    end
                endcase
                if (last) begin
                    run_r     <= 1'b0;
                    cmd_ready <= 1'b1;
                    rsp_valid <= 1'b1;
                    rsp_data  <= (op_r == OP_READ) ? sh_r : 8'h00;
                end
            end
        end
    end

    assign bus.m_scl_oe = scl_oe_r;
    assign bus.m_scl_o  = zero_r;
    assign bus.m_sda_oe = sda_oe_r;
    assign bus.m_sda_o  = zero_r;

endmodule : two_wire_master
`default_nettype wire

// ### dv/eeprom_link_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module eeprom_link_monitor #(
    parameter int WR_CYC = 200                 // write cycle length
)(
    input wire logic link_clk,                 // link clock
    input wire logic sys_rst,                  // async reset
    input wire logic scl,                      // clock wire
    input wire logic sda,                      // data wire
    input wire logic s_sda_oe,                 // device drives data
    input wire logic rst_out_active,           // abort request
    input wire logic nv_busy,                  // write cycle running
    input wire logic nv_we                     // array strobe
);
    localparam int BUSY_MAX = WR_CYC + 68;
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (sys_rst);
    logic [15:0] busy_cnt_r;
    // busy span count: a stuck busy would lock the bus for good
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst)
            busy_cnt_r <= '0;
        else
            busy_cnt_r <= nv_busy ? busy_cnt_r + 16'h0001 : 16'h0000;
    end
    sequence abort_held;
        // the device synchronises the reset output, so allow its latency
        rst_out_active [*4];
    endsequence
    busy_quiet_a: assert property (nv_busy |-> !s_sda_oe)
        else $error("device drives data while busy");
    high_hold_a: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
        else $error("device data changed with clock high");
    drive_low_a: assert property ($rose(s_sda_oe) |-> !scl)
        else $error("device took the line with clock high");
    release_low_a: assert property ($fell(s_sda_oe) && !rst_out_active |-> !scl)
        else $error("device released the line with clock high");
    strobe_busy_a: assert property (nv_we |-> nv_busy)
        else $error("array strobe outside write cycle");
    commit_stop_a: assert property ($rose(nv_busy) |-> scl && sda)
        else $error("write cycle began without a stop");
    abort_free_a: assert property (abort_held ##0 !nv_busy |-> !s_sda_oe)
        else $error("device drives during reset output");
    busy_span_a: assert property (busy_cnt_r <= BUSY_MAX)
        else $error("write cycle too long");
endmodule : eeprom_link_monitor
`default_nettype wire

// ### dv/test_eeprom_two_wire_slave.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin bad_count++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module test_eeprom_two_wire_slave;
    import eeprom_pkg::*;
    logic          clock, link_clk, sys_rst, cmd_valid, cmd_mack, cmd_ready, rsp_valid;
    logic          rsp_ack, rst_out_active, nv_we, nv_busy, wp_hit;
    op_t           cmd_op;
    logic [7:0]    cmd_data, rsp_data, rd_data, nv_data, wsel;
    logic [1:0]    dev_sel;
    logic [AW-1:0] word_addr, nv_addr, wp_lim, ra;
    logic [7:0]    mem [2**AW];
    logic [7:0]    ref_mem [2**AW];
    logic [31:0]   seed = 32'h979c_a48f;
    int            bad_count = 0, check_count = 0, k;
    two_wire_if bus ();
    two_wire_master #(.QTR(8)) two_wire_master_i (.clock, .sys_rst, .bus(bus), .cmd_valid,
        .cmd_op, .cmd_data, .cmd_mack, .cmd_ready, .rsp_valid, .rsp_data, .rsp_ack);
    eeprom_link_dev #(.WR_CYC(200)) eeprom_link_dev_i (.link_clk, .sys_rst, .bus(bus),
        .dev_sel, .rst_out_active, .wp_hit, .rd_data, .word_addr, .nv_we, .nv_addr,
        .nv_data, .nv_busy);
    eeprom_link_monitor #(.WR_CYC(200)) eeprom_link_monitor_i (.link_clk, .sys_rst,
        .scl(bus.scl), .sda(bus.sda), .s_sda_oe(bus.s_sda_oe), .rst_out_active, .nv_busy,
        .nv_we);
    // array stand-in: combinational read, written by commit strobes
    assign rd_data = mem[word_addr];
    assign wp_hit = word_addr < wp_lim;
    assign wsel = {DEV_TYPE, 1'b0, dev_sel, 1'b0};
    always @(posedge link_clk) if (nv_we) mem[nv_addr] <= nv_data;
    initial begin clock = 0; forever #25 clock = ~clock; end
    // link clock phase offset keeps the two domains unrelated
    initial begin link_clk = 0; #17; forever #62.5 link_clk = ~link_clk; end
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : xs
    task automatic summarize();
        $display("checks %0d bad %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    // one master command; held for one clock, then waited out under a bound
    task automatic cmd(op_t op, logic [7:0] d, logic mk);
        int n = 0;
        cmd_op <= op;
        cmd_data <= d;
        cmd_mack <= mk;
        cmd_valid <= 1'b1;
        @(posedge clock);
        cmd_valid <= 1'b0;
        do begin @(posedge clock); n++; end while (rsp_valid !== 1'b1 && n < 1000);
        if (n >= 1000) bad_count++;
    endtask : cmd
    task automatic slave(logic [7:0] b);
        cmd(OP_START, 8'h00, 1'b0);
        cmd(OP_WRITE, b, 1'b0);
    endtask : slave
    task automatic addr(logic [AW-1:0] a);
        slave(wsel);
        cmd(OP_WRITE, {5'h00, a[10:8]}, 1'b0);
        cmd(OP_WRITE, a[7:0], 1'b0);
    endtask : addr
    // write n random bytes from a, stop, then poll the write cycle out unless pr
    task automatic wr(logic [AW-1:0] a, int n, logic pr);
        logic [7:0] d;
        int i;
        addr(a);
        `CHK("addr ack", 1'b1, rsp_ack)
        for (i = 0; i < n; i++) begin
            d = xs();
            cmd(OP_WRITE, d, 1'b0);
            `CHK("data ack", !pr, rsp_ack)
            if (!pr) ref_mem[{a[10:6], a[5:0] + i[5:0]}] = d;
        end
        cmd(OP_STOP, 8'h00, 1'b0);
        if (!pr) begin
            slave(wsel);
            `CHK("poll nack", 1'b0, rsp_ack)
            for (i = 0; i < 12 && rsp_ack !== 1'b1; i++) begin
                cmd(OP_STOP, 8'h00, 1'b0);
                slave(wsel);
            end
            `CHK("poll ack", 1'b1, rsp_ack)
            cmd(OP_STOP, 8'h00, 1'b0);
        end
    endtask : wr
    // random or current read of n bytes against the expected array
    task automatic rd(logic [AW-1:0] a, int n, logic cur);
        int i;
        if (!cur) addr(a);
        slave(wsel | 8'h01);
        `CHK("read ack", 1'b1, rsp_ack)
        for (i = 0; i < n; i++) begin
            cmd(OP_READ, 8'h00, i < n - 1);
            `CHK("read data", ref_mem[a + i[AW-1:0]], rsp_data)
        end
        cmd(OP_STOP, 8'h00, 1'b0);
    endtask : rd
    initial begin
        repeat (90000) @(posedge clock);
        bad_count++;
        summarize();
    end
    initial begin
        sys_rst = 1'b1;
        {cmd_valid, cmd_mack, rst_out_active, cmd_data, wp_lim} = '0;
        cmd_op = OP_START;
        dev_sel = 2'(xs());
        for (k = 0; k < 2**AW; k++) begin mem[k] = 8'h00; ref_mem[k] = 8'h00; end
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clock);
        wr(11'h07c, 12, 1'b0);
        rd(11'h040, 8, 1'b0);
        rd(11'h07c, 4, 1'b0);
        rd(11'h080, 1, 1'b1);
        addr(11'h3ff);
        cmd(OP_STOP, 8'h00, 1'b0);
        rd(11'h3ff, 2, 1'b1);
        rd(11'h7ff, 2, 1'b0);
        for (k = 0; k < 3; k++) begin
            slave(wsel ^ (k == 0 ? 8'h06 : k == 1 ? 8'h80 : 8'h08));
            `CHK("reject", 1'b0, rsp_ack)
            cmd(OP_STOP, 8'h00, 1'b0);
        end
        wp_lim <= 11'h200;
        wr(11'h100, 1, 1'b1);
        wp_lim <= 11'h000;
        rd(11'h100, 1, 1'b0);
        rst_out_active <= 1'b1;
        slave(wsel);
        `CHK("abort", 1'b0, rsp_ack)
        cmd(OP_STOP, 8'h00, 1'b0);
        rst_out_active <= 1'b0;
        ra = {xs(), 3'h0};
        wr(ra, 66, 1'b0);
        rd({ra[10:6], 6'h00}, 8, 1'b0);
        for (k = 0; k < 2; k++) begin
            ra = AW'({xs(), xs()});
            wr(ra, xs() % 8 + 1, 1'b0);
            rd(ra, 6, 1'b0);
        end
        summarize();
    end
endmodule : test_eeprom_two_wire_slave
`default_nettype wire
